/* File: verilog/fp_pipe_map.vh */
`ifndef FP_PIPE_MAP_VH
`define FP_PIPE_MAP_VH
`define CTRL_OFF 8'h00
`define STAT_OFF 8'h04
`define CTRL_FLOW_BIT 0
`define CTRL_FAST_BIT 1
`define CTRL_RM_LSB 2
`define CTRL_RST 4'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define FN_ADD 3'h0
`define FN_SUB 3'h1
`define FN_MUL 3'h2
`define FN_ABS 3'h3
`define FN_FIX2FLT 3'h4
`define FN_FLT2FIX 3'h5
`define RM_NEAR 2'h0
`define RM_ZERO 2'h1
`define RM_PINF 2'h2
`define RM_NINF 2'h3
`define EXC_INV 4'h8
`define EXC_OVF 4'h4
`define EXC_UNF 4'h2
`define EXC_INX 4'h1
`define QNAN 32'h7FC00000
`define MAX_FIN 31'h7F7FFFFF
`define FIX_POS_SAT 32'h007FFFFF
`define FIX_NEG_SAT 32'hFF800000
`define EXP_BIAS 12'h07F
`define FIX_EXP 12'h096
`define EXP_MAX 12'h0FF
`define REC_W 101
`define TOK_W 9
`define TOK_S1 1
`define TOK_S2 3
`define TOK_S3 5
`define TOK_OUT_FLOW 7
`define TOK_OUT_PIPE 8
`endif

/* File: verilog/fp_pipe_unit.v */
`include "fp_pipe_map.vh"
`default_nettype none
module fp_pipe_unit (
   input wire clk_i,
   input wire rstn_i,
   input wire load_i,
   input wire [15:0] a_half_i,
   input wire [15:0] b_half_i,
   input wire [2:0] func_i,
   input wire unload_i,
   input wire out_en_i,
   output wire [15:0] res_o,
   output wire res_oe_o,
   output wire res_avail_o,
   output wire [3:0] exc_o,
   input wire [7:0] awaddr_i,
   input wire awvalid_i,
   output wire awready_o,
   input wire [31:0] wdata_i,
   input wire [3:0] wstrb_i,
   input wire wvalid_i,
   output wire wready_o,
   output wire [1:0] bresp_o,
   output wire bvalid_o,
   input wire bready_i,
   input wire [7:0] araddr_i,
   input wire arvalid_i,
   output wire arready_o,
   output wire [31:0] rdata_o,
   output wire [1:0] rresp_o,
   output wire rvalid_o,
   input wire rready_i
);

   // Right shift that folds every lost bit into bit 0
   function [47:0] shr_st;
      input [47:0] v;
      input [11:0] n;
      reg [47:0] r;
      begin
         if (n > 12'd47) begin
            shr_st = {47'h0, |v};
         end else begin
            r = v >> n;
            shr_st = {r[47:1], r[0] | ((r << n) != v)};
         end
      end
   endfunction

   function rnd;
      input [1:0] rm;
      input s;
      input lsb;
      input g;
      input st;
      begin
         case (rm)
            `RM_NEAR: rnd = g & (st | lsb);
            `RM_PINF: rnd = ~s & (g | st);
            `RM_NINF: rnd = s & (g | st);
            default: rnd = 1'b0;
         endcase
      end
   endfunction

   reg [3:0] ctrl_q;
   reg [3:0] sticky_q;
   reg [3:0] inflight_q;
   reg ld_ph_q;
   reg [15:0] a_hi_q;
   reg [15:0] b_hi_q;
   reg [2:0] f_hi_q;
   reg [31:0] ld_a_q;
   reg [31:0] ld_b_q;
   reg [2:0] ld_f_q;
   reg [1:0] ld_rm_q;
   reg ld_fast_q;
   reg [`TOK_W-1:0] tok_q;
   reg [`REC_W-1:0] st1_q;
   reg [`REC_W-1:0] st2_q;
   reg [35:0] st3_q;
   reg [35:0] st4_q;
   reg [31:0] out_word_q;
   reg [3:0] out_exc_q;
   reg res_avail_q;
   reg ul_ph_q;
   reg [15:0] res_q;
   reg res_oe_q;

   wire flow = ctrl_q[`CTRL_FLOW_BIT];

   // Load stage operand decode
   wire [7:0] ea = ld_a_q[30:23];
   wire [7:0] eb = ld_b_q[30:23];
   wire [23:0] ma = {|ea, ld_a_q[22:0]};
   wire [23:0] mb = {|eb, ld_b_q[22:0]};
   wire [7:0] xa = (ea == 8'h00) ? 8'h01 : ea;
   wire [7:0] xb = (eb == 8'h00) ? 8'h01 : eb;
   wire a_inf = (&ea) & ~|ld_a_q[22:0];
   wire b_inf = (&eb) & ~|ld_b_q[22:0];
   wire a_nan = (&ea) & |ld_a_q[22:0];
   wire b_nan = (&eb) & |ld_b_q[22:0];
   wire a_snan = a_nan & ~ld_a_q[22];
   wire b_snan = b_nan & ~ld_b_q[22];
   wire a_zero = ~|ld_a_q[30:0];
   wire b_zero = ~|ld_b_q[30:0];
   wire b_s = ld_b_q[31] ^ (ld_f_q == `FN_SUB);
   wire swap = ld_b_q[30:0] > ld_a_q[30:0];
   wire [7:0] d = swap ? xb - xa : xa - xb;
   wire [47:0] big = {1'b0, swap ? mb : ma, 23'h000000};
   wire [47:0] sml = shr_st({1'b0, swap ? ma : mb, 23'h000000}, {4'h0, d});
   wire [23:0] fix_mag = ld_a_q[23] ? 24'h000000 - ld_a_q[23:0] : ld_a_q[23:0];

   // Array stage 1: specials, alignment and add, product, conversion shift
   reg n_s;
   reg [11:0] n_e;
   reg [47:0] n_m;
   reg n_sp;
   reg [31:0] n_spv;
   reg n_inv;

   always @* begin
      n_s = ld_a_q[31];
      n_e = 12'h000;
      n_m = 48'h0;
      n_sp = 1'b0;
      n_spv = `QNAN;
      n_inv = 1'b0;
      case (ld_f_q)
         `FN_ADD, `FN_SUB: begin
            if (a_nan | b_nan) begin
               n_sp = 1'b1;
               n_inv = a_snan | b_snan;
            end else if (a_inf & b_inf & (ld_a_q[31] != b_s)) begin
               n_sp = 1'b1;
               n_inv = 1'b1;
            end else if (a_inf | b_inf) begin
               n_sp = 1'b1;
               n_spv = {a_inf ? ld_a_q[31] : b_s, 8'hFF, 23'h0};
            end else begin
               n_s = swap ? b_s : ld_a_q[31];
               n_e = {4'h0, swap ? xb : xa};
               n_m = (ld_a_q[31] == b_s) ? big + sml : big - sml;
               // Exact cancellation gives +0 except when rounding down
               if (n_m == 48'h0 && ld_a_q[31] != b_s) begin
                  n_s = (ld_rm_q == `RM_NINF);
               end
            end
         end
         `FN_MUL: begin
            n_s = ld_a_q[31] ^ ld_b_q[31];
            if (a_nan | b_nan) begin
               n_sp = 1'b1;
               n_inv = a_snan | b_snan;
            end else if ((a_inf & b_zero) | (b_inf & a_zero)) begin
               n_sp = 1'b1;
               n_inv = 1'b1;
            end else if (a_inf | b_inf) begin
               n_sp = 1'b1;
               n_spv = {n_s, 8'hFF, 23'h0};
            end else begin
               n_e = {4'h0, xa} + {4'h0, xb} - `EXP_BIAS;
               n_m = ma * mb;
            end
         end
         `FN_ABS: begin
            n_sp = 1'b1;
            n_spv = {1'b0, ld_a_q[30:0]};
         end
         `FN_FIX2FLT: begin
            n_s = ld_a_q[23];
            n_e = `FIX_EXP;
            n_m = {1'b0, fix_mag, 23'h000000};
         end
         `FN_FLT2FIX: begin
            if (a_nan | a_inf | ({4'h0, ea} > `FIX_EXP)) begin
               n_sp = 1'b1;
               n_inv = 1'b1;
               n_spv = (a_nan | ~ld_a_q[31]) ? `FIX_POS_SAT : `FIX_NEG_SAT;
            end else begin
               n_s = ld_a_q[31];
               if ({4'h0, xa} >= `EXP_BIAS) begin
                  n_m = {24'h000000, ma} << (xa - 8'h7F);
               end else begin
                  n_m = shr_st({24'h000000, ma}, `EXP_BIAS - {4'h0, xa});
               end
            end
         end
         default: begin
            n_sp = 1'b1;
            n_inv = 1'b1;
         end
      endcase
   end

   // Function and rounding controls ride along with each operand set
   wire [`REC_W-1:0] s1_rec = {ld_f_q, ld_rm_q, ld_fast_q, n_s, n_e, n_m, n_sp, n_spv, n_inv};

   // Array stage 2: renormalise so the leading one sits at bit 47
   wire [`REC_W-1:0] src2 = flow ? s1_rec : st1_q;
   wire [2:0] x_f;
   wire [1:0] x_rm;
   wire x_fast;
   wire x_s;
   wire [11:0] x_e;
   wire [47:0] x_m;
   wire x_sp;
   wire [31:0] x_spv;
   wire x_inv;
   assign {x_f, x_rm, x_fast, x_s, x_e, x_m, x_sp, x_spv, x_inv} = src2;

   reg [5:0] lz;
   reg [47:0] nz_m;
   reg [11:0] nz_e;
   integer i;

   always @* begin
      lz = 6'd0;
      for (i = 0; i < 48; i = i + 1) begin
         if (x_m[i]) begin
            lz = 6'd47 - i[5:0];
         end
      end
      nz_m = x_m;
      nz_e = x_e;
      if (!x_sp && x_f != `FN_FLT2FIX && x_m != 48'h0) begin
         nz_m = x_m << lz;
         nz_e = x_e + 12'h001 - {6'h00, lz};
      end
   end

   wire [`REC_W-1:0] s2_rec = {x_f, x_rm, x_fast, x_s, nz_e, nz_m, x_sp, x_spv, x_inv};

   // Array stage 3: denormalise, round, pack, flag
   wire [`REC_W-1:0] src3 = flow ? s2_rec : st2_q;
   wire [2:0] y_f;
   wire [1:0] y_rm;
   wire y_fast;
   wire y_s;
   wire [11:0] y_e;
   wire [47:0] y_m;
   wire y_sp;
   wire [31:0] y_spv;
   wire y_inv;
   assign {y_f, y_rm, y_fast, y_s, y_e, y_m, y_sp, y_spv, y_inv} = src3;

   reg [31:0] r_word;
   reg [3:0] r_exc;
   reg [47:0] dm;
   reg [24:0] rr;
   reg [23:0] fx;
   reg [11:0] ee;
   reg tiny;
   reg inx;
   reg ovf_inf;

   always @* begin
      r_word = y_spv;
      r_exc = y_inv ? `EXC_INV : 4'h0;
      dm = 48'h0;
      rr = 25'h0;
      fx = 24'h0;
      ee = 12'h000;
      tiny = 1'b0;
      inx = 1'b0;
      ovf_inf = (y_rm == `RM_NEAR) | ((y_rm == `RM_PINF) & ~y_s) | ((y_rm == `RM_NINF) & y_s);
      if (y_sp) begin
         r_word = y_spv;
      end else if (y_f == `FN_FLT2FIX) begin
         inx = y_m[22] | |y_m[21:0];
         rr = {1'b0, y_m[46:23]} + {24'h0, rnd(y_rm, y_s, y_m[23], y_m[22], |y_m[21:0])};
         if (y_s ? rr > 25'h0800000 : rr > 25'h07FFFFF) begin
            r_word = y_s ? `FIX_NEG_SAT : `FIX_POS_SAT;
            r_exc = `EXC_INV;
         end else begin
            fx = y_s ? 24'h000000 - rr[23:0] : rr[23:0];
            r_word = {{8{fx[23]}}, fx};
            r_exc = inx ? `EXC_INX : 4'h0;
         end
      end else if (y_m == 48'h0) begin
         r_word = {y_s, 31'h0};
      end else begin
         tiny = $signed(y_e) < $signed(12'h001);
         dm = tiny ? shr_st(y_m, 12'h001 - y_e) : y_m;
         ee = tiny ? 12'h000 : y_e;
         inx = dm[23] | |dm[22:0];
         if (tiny & y_fast & (y_f == `FN_MUL)) begin
            r_word = {y_s, 31'h0};
            r_exc = `EXC_UNF | `EXC_INX;
         end else begin
            rr = {1'b0, dm[47:24]} + {24'h0, rnd(y_rm, y_s, dm[24], dm[23], |dm[22:0])};
            if (rr[24]) begin
               ee = ee + 12'h001;
            end else if (ee == 12'h000 && rr[23]) begin
               ee = 12'h001;
            end
            if (ee >= `EXP_MAX) begin
               r_word = ovf_inf ? {y_s, 8'hFF, 23'h0} : {y_s, `MAX_FIN};
               r_exc = `EXC_OVF | `EXC_INX;
            end else begin
               r_word = {y_s, ee[7:0], rr[22:0]};
               r_exc = ((tiny & inx) ? `EXC_UNF : 4'h0) | (inx ? `EXC_INX : 4'h0);
            end
         end
      end
   end

   wire out_cap = flow ? tok_q[`TOK_OUT_FLOW] : tok_q[`TOK_OUT_PIPE];
   wire op_start = load_i & ~ld_ph_q;
   wire op_done = load_i & ld_ph_q;
   wire [3:0] exc_new = flow ? r_exc : st4_q[3:0];
   wire wr_go;
   wire [3:0] st_clr;

   // Datapath registers move on the rising clock edge; flowthrough mode bypasses the stage registers and reset clears them asynchronously
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ld_ph_q <= 1'b0;
         a_hi_q <= 16'h0000;
         b_hi_q <= 16'h0000;
         f_hi_q <= 3'h0;
         ld_a_q <= 32'h0;
         ld_b_q <= 32'h0;
         ld_f_q <= 3'h0;
         ld_rm_q <= 2'h0;
         ld_fast_q <= 1'b0;
         tok_q <= {`TOK_W{1'b0}};
         st1_q <= {`REC_W{1'b0}};
         st2_q <= {`REC_W{1'b0}};
         st3_q <= 36'h0;
         st4_q <= 36'h0;
         out_word_q <= 32'h0;
         out_exc_q <= 4'h0;
         inflight_q <= 4'h0;
         res_avail_q <= 1'b0;
         ul_ph_q <= 1'b0;
         res_q <= 16'h0000;
         res_oe_q <= 1'b0;
         sticky_q <= 4'h0;
      end else begin
         if (load_i) begin
            ld_ph_q <= ~ld_ph_q;
            if (!ld_ph_q) begin
               a_hi_q <= a_half_i;
               b_hi_q <= b_half_i;
               f_hi_q <= func_i;
            end else begin
               ld_a_q <= {a_hi_q, a_half_i};
               ld_b_q <= {b_hi_q, b_half_i};
               ld_f_q <= f_hi_q;
               ld_rm_q <= ctrl_q[`CTRL_RM_LSB+1:`CTRL_RM_LSB];
               ld_fast_q <= ctrl_q[`CTRL_FAST_BIT];
            end
         end
         tok_q <= {tok_q[`TOK_W-2:0], op_done};
         // Each stage holds for two cycles, enough for a new pair every other cycle
         if (tok_q[`TOK_S1]) begin
            st1_q <= s1_rec;
         end
         if (tok_q[`TOK_S2]) begin
            st2_q <= s2_rec;
         end
         if (tok_q[`TOK_S3]) begin
            st3_q <= {r_word, r_exc};
         end
         // Hold slot: the next op reaches stage 3 before this one is unloaded
         if (tok_q[`TOK_S3+2]) begin
            st4_q <= st3_q;
         end
         if (out_cap) begin
            out_word_q <= flow ? r_word : st4_q[35:4];
            out_exc_q <= exc_new;
         end
         inflight_q <= inflight_q + {3'h0, op_start} - {3'h0, out_cap};
         res_avail_q <= out_cap | (res_avail_q & ~(unload_i & ul_ph_q));
         if (unload_i) begin
            ul_ph_q <= ~ul_ph_q;
            res_q <= ul_ph_q ? out_word_q[15:0] : out_word_q[31:16];
         end
         res_oe_q <= out_en_i;
         // A new flag beats a clear in the same cycle
         sticky_q <= (sticky_q & ~st_clr) | (out_cap ? exc_new : 4'h0);
      end
   end

   assign res_o = res_q;
   assign res_oe_o = res_oe_q;
   assign res_avail_o = res_avail_q;
   assign exc_o = out_exc_q;

   // Register slave: write address and data may arrive in either order
   reg aw_h_q;
   reg [7:0] aw_a_q;
   reg w_h_q;
   reg [31:0] w_d_q;
   reg [3:0] w_s_q;
   reg bvalid_q;
   reg [1:0] bresp_q;
   reg rvalid_q;
   reg [31:0] rdata_q;
   reg [1:0] rresp_q;

   assign wr_go = aw_h_q & w_h_q & ~bvalid_q;
   assign st_clr = (wr_go && aw_a_q == `STAT_OFF && w_s_q[0]) ? w_d_q[3:0] : 4'h0;
   assign awready_o = ~aw_h_q;
   assign wready_o = ~w_h_q;
   assign bvalid_o = bvalid_q;
   assign bresp_o = bresp_q;
   assign arready_o = ~rvalid_q;
   assign rvalid_o = rvalid_q;
   assign rdata_o = rdata_q;
   assign rresp_o = rresp_q;

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         aw_h_q <= 1'b0;
         aw_a_q <= 8'h00;
         w_h_q <= 1'b0;
         w_d_q <= 32'h0;
         w_s_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= `RESP_OKAY;
         ctrl_q <= `CTRL_RST;
      end else begin
         if (awvalid_i & ~aw_h_q) begin
            aw_h_q <= 1'b1;
            aw_a_q <= awaddr_i;
         end
         if (wvalid_i & ~w_h_q) begin
            w_h_q <= 1'b1;
            w_d_q <= wdata_i;
            w_s_q <= wstrb_i;
         end
         if (wr_go) begin
            aw_h_q <= 1'b0;
            w_h_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= (aw_a_q == `CTRL_OFF || aw_a_q == `STAT_OFF) ? `RESP_OKAY : `RESP_SLVERR;
            if (aw_a_q == `CTRL_OFF && w_s_q[0]) begin
               ctrl_q <= w_d_q[3:0];
            end
         end else if (bvalid_q & bready_i) begin
            bvalid_q <= 1'b0;
         end
         if (arvalid_i & ~rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q <= `RESP_OKAY;
            case (araddr_i)
               `CTRL_OFF: rdata_q <= {28'h0, ctrl_q};
               `STAT_OFF: rdata_q <= {23'h0, res_avail_q, inflight_q, sticky_q};
               default: begin
                  rdata_q <= 32'h0;
                  rresp_q <= `RESP_SLVERR;
               end
            endcase
         end else if (rvalid_q & rready_i) begin
            rvalid_q <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

/* File: test/fp_pipe_unit_asserts.sv */
`include "fp_pipe_map.vh"
`default_nettype none
module fp_pipe_unit_chk (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic load_i,
   input wire logic unload_i,
   input wire logic out_en_i,
   input wire logic [15:0] res_o,
   input wire logic res_oe_o,
   input wire logic res_avail_o,
   input wire logic [3:0] exc_o,
   input wire logic [7:0] awaddr_i,
   input wire logic awvalid_i,
   input wire logic awready_o,
   input wire logic [31:0] wdata_i,
   input wire logic wvalid_i,
   input wire logic wready_o,
   input wire logic [1:0] bresp_o,
   input wire logic bvalid_o,
   input wire logic bready_i,
   input wire logic [31:0] rdata_o,
   input wire logic rvalid_o,
   input wire logic rready_i
);
   logic lo_q;
   logic flow_q;
   // Mode followed from control writes; assumes address and data taken together
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lo_q <= 1'b0;
         flow_q <= 1'b0;
      end else begin
         if (load_i) lo_q <= ~lo_q;
         if (awvalid_i && awready_o && wvalid_i && wready_o && awaddr_i == `CTRL_OFF)
            flow_q <= wdata_i[`CTRL_FLOW_BIT];
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   a_pipe_latency: assert property (load_i && !lo_q && !flow_q |-> ##11 res_avail_o)
      else $error("pipeline result late");
   a_flow_latency: assert property (
      load_i && !lo_q && flow_q |-> ##9 !res_avail_o ##1 res_avail_o)
      else $error("flowthrough result timing wrong");
   a_avail_cause: assert property (
      $rose(res_avail_o) |-> $past(load_i, 10) || $past(load_i, 9))
      else $error("result appeared without operand");
   a_exc_cause: assert property (
      !$past(load_i, 9) && !$past(load_i, 10) |-> $stable(exc_o))
      else $error("exceptions changed without result");
   a_res_held: assert property (!unload_i |=> $stable(res_o))
      else $error("result port moved without unload");
   a_avail_held: assert property (res_avail_o && !unload_i |=> res_avail_o)
      else $error("result lost before unload");
   a_oe_follow: assert property (out_en_i |=> res_oe_o)
      else $error("result port not driven");
   a_oe_release: assert property (!out_en_i |=> !res_oe_o)
      else $error("result port not released");
   a_b_hold: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
      else $error("write response dropped");
   a_r_hold: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
      else $error("read data dropped");
endmodule
bind fp_pipe_unit fp_pipe_unit_chk chk (.clk_i, .rstn_i, .load_i, .unload_i, .out_en_i,
   .res_o, .res_oe_o, .res_avail_o, .exc_o, .awaddr_i, .awvalid_i, .awready_o, .wdata_i,
   .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .rdata_o, .rvalid_o, .rready_i);
`default_nettype wire

/* File: test/fp_host_model.sv */
`default_nettype none
module fp_host_model (
   input wire logic clk_i,
   output logic load_o,
   output logic [15:0] a_o,
   output logic [15:0] b_o,
   output logic [2:0] func_o,
   output logic unload_o,
   input wire logic [15:0] res_i,
   input wire logic [3:0] exc_i
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] got[8];
   logic [3:0] flg[8];
   initial begin
      load_o = 1'b0;
      a_o = 16'h0000;
      b_o = 16'h0000;
      func_o = 3'h0;
      unload_o = 1'b0;
   end
   task automatic issue(input logic [31:0] a, input logic [31:0] b, input logic [2:0] f);
      load_o <= 1'b1;
      a_o <= a[31:16];
      b_o <= b[31:16];
      func_o <= f;
      @(posedge clk_i);
      a_o <= a[15:0];
      b_o <= b[15:0];
      func_o <= ~f;
      @(posedge clk_i);
   endtask
   // Idle lines scrambled so a stale half is never taken for data
   task automatic rest();
      load_o <= 1'b0;
      a_o <= ~a_o;
      b_o <= ~b_o;
   endtask
   task automatic collect(input int d, input int n);
      int i;
      repeat (d) @(posedge clk_i);
      unload_o <= 1'b1;
      for (i = 0; i <= 2 * n; i++) begin
         @(posedge clk_i);
         if (i % 2 == 0 && i < 2 * n) flg[i / 2] = exc_i;
         if (i % 2 == 1) got[i / 2][31:16] = res_i;
         if (i % 2 == 0 && i > 0) got[i / 2 - 1][15:0] = res_i;
         if (i == 2 * n - 1) unload_o <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

/* File: test/test_float_pipeline_arith_unit.sv */
`include "fp_pipe_map.vh"
`default_nettype none
module test_float_pipeline_arith_unit;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic out_en_i = 1'b1;
   logic [7:0] awaddr_i = 8'h00;
   logic awvalid_i = 1'b0;
   logic [31:0] wdata_i = 32'h00000000;
   logic [3:0] wstrb_i = 4'hF;
   logic wvalid_i = 1'b0;
   logic bready_i = 1'b0;
   logic [7:0] araddr_i = 8'h00;
   logic arvalid_i = 1'b0;
   logic rready_i = 1'b0;
   wire logic load_i;
   wire logic unload_i;
   wire logic [15:0] a_half_i;
   wire logic [15:0] b_half_i;
   wire logic [2:0] func_i;
   wire logic [15:0] res_o;
   wire logic res_oe_o;
   wire logic res_avail_o;
   wire logic [3:0] exc_o;
   wire logic awready_o;
   wire logic wready_o;
   wire logic [1:0] bresp_o;
   wire logic bvalid_o;
   wire logic arready_o;
   wire logic [31:0] rdata_o;
   wire logic [1:0] rresp_o;
   wire logic rvalid_o;
   int failures = 0;
   int compares = 0;
   logic [31:0] opa[8] = '{32'h3F800000, 32'h40400000, 32'h40000000, 32'hC0A00000,
      32'h00000005, 32'h40A00000, 32'h3F800000, 32'h7F7FFFFF};
   logic [31:0] opb[8] = '{32'h40000000, 32'h3F800000, 32'h40400000, 32'hC0A00000,
      32'h00000005, 32'h40A00000, 32'h3F800000, 32'h40000000};
   logic [2:0] opf[8] = '{`FN_ADD, `FN_SUB, `FN_MUL, `FN_ABS, `FN_FIX2FLT, `FN_FLT2FIX,
      3'h6, `FN_MUL};
   logic [31:0] opr[8] = '{32'h40400000, 32'h40000000, 32'h40C00000, 32'h40A00000,
      32'h40A00000, 32'h00000005, `QNAN, 32'h7F800000};
   logic [3:0] opx[8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, `EXC_INV, `EXC_OVF | `EXC_INX};
   fp_pipe_unit uut (.clk_i, .rstn_i, .load_i, .a_half_i, .b_half_i, .func_i, .unload_i,
      .out_en_i, .res_o, .res_oe_o, .res_avail_o, .exc_o, .awaddr_i, .awvalid_i, .awready_o,
      .wdata_i, .wstrb_i, .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i,
      .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i);
   fp_host_model host (.clk_i, .load_o(load_i), .a_o(a_half_i), .b_o(b_half_i),
      .func_o(func_i), .unload_o(unload_i), .res_i(res_o), .exc_i(exc_o));
   initial forever #50 clk_i = ~clk_i;
   task automatic stop_test();
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         failures++;
         $display("mismatch t=%0t word %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_f(input logic [3:0] g, input logic [3:0] e);
      compares++;
      if (g !== e) begin
         failures++;
         $display("mismatch t=%0t code %h expected %h", $time, g, e);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                         output logic [1:0] r);
      awaddr_i <= a;
      awvalid_i <= 1'b1;
      wdata_i <= d;
      wstrb_i <= s;
      wvalid_i <= 1'b1;
      bready_i <= 1'b1;
      do begin
         @(posedge clk_i);
         if (awready_o) awvalid_i <= 1'b0;
         if (wready_o) wvalid_i <= 1'b0;
      end while (!bvalid_o);
      r = bresp_o;
      bready_i <= 1'b0;
      // Idle edge so a following call never re-raises a just lowered line
      @(posedge clk_i);
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr_i <= a;
      arvalid_i <= 1'b1;
      rready_i <= 1'b1;
      do begin
         @(posedge clk_i);
         if (arready_o) arvalid_i <= 1'b0;
      end while (!rvalid_o);
      d = rdata_o;
      r = rresp_o;
      rready_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, 4'hF, r);
      chk_f({2'h0, r}, {2'h0, `RESP_OKAY});
   endtask
   task automatic op1(input int d, input logic [31:0] a, input logic [31:0] b,
                      input logic [2:0] f, input logic [31:0] er, input logic [3:0] ex);
      fork
         begin
            host.issue(a, b, f);
            host.rest();
         end
         host.collect(d, 1);
      join
      chk_w(host.got[0], er);
      chk_f(host.flg[0], ex);
      chk_f({3'h0, res_avail_o}, 4'h0);
   endtask
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(`CTRL_OFF, d, r);
      chk_w(d, 32'h00000000);
      axi_rd(8'h10, d, r);
      chk_w(d, 32'h00000000);
      chk_f({2'h0, r}, {2'h0, `RESP_SLVERR});
      axi_wr(8'h10, 32'hFFFFFFFF, 4'hF, r);
      chk_f({2'h0, r}, {2'h0, `RESP_SLVERR});
      // Low byte strobe off: control must not move
      axi_wr(`CTRL_OFF, 32'h0000000C, 4'hE, r);
      axi_rd(`CTRL_OFF, d, r);
      chk_w(d, 32'h00000000);
   endtask
   task automatic t_pipe();
      int k;
      fork
         begin
            for (k = 0; k < 8; k++) host.issue(opa[k], opb[k], opf[k]);
            host.rest();
         end
         host.collect(11, 8);
      join
      for (k = 0; k < 8; k++) begin
         chk_w(host.got[k], opr[k]);
         chk_f(host.flg[k], opx[k]);
      end
   endtask
   task automatic t_flow();
      wr(`CTRL_OFF, 32'h00000001);
      op1(10, 32'h40000000, 32'h40400000, `FN_MUL, 32'h40C00000, 4'h0);
      op1(10, 32'h40400000, 32'h3F800000, `FN_SUB, 32'h40000000, 4'h0);
      wr(`CTRL_OFF, 32'h00000000);
   endtask
   task automatic t_round();
      logic [31:0] d;
      logic [1:0] r;
      int m;
      for (m = 0; m < 4; m++) begin
         wr(`CTRL_OFF, {28'h0000000, m[1:0], 2'h0});
         axi_rd(`CTRL_OFF, d, r);
         chk_w(d, {28'h0000000, m[1:0], 2'h0});
         op1(11, 32'h3F800000, 32'h33800000, `FN_ADD,
            (m == `RM_PINF) ? 32'h3F800001 : 32'h3F800000, `EXC_INX);
      end
      wr(`CTRL_OFF, 32'h00000000);
   endtask
   task automatic t_fast();
      logic [31:0] d;
      logic [1:0] r;
      wr(`STAT_OFF, 32'h0000000F);
      wr(`CTRL_OFF, 32'h00000002);
      op1(11, 32'h00800000, 32'h3F000000, `FN_MUL, 32'h0, `EXC_UNF | `EXC_INX);
      axi_rd(`STAT_OFF, d, r);
      chk_w(d, 32'h00000003);
      wr(`CTRL_OFF, 32'h00000000);
      op1(11, 32'h00800000, 32'h3F000000, `FN_MUL, 32'h00400000, 4'h0);
   endtask
   task automatic t_oe();
      out_en_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk_f({3'h0, res_oe_o}, 4'h0);
      out_en_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk_f({3'h0, res_oe_o}, 4'h1);
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      t_regs();
      t_pipe();
      t_flow();
      t_round();
      t_fast();
      t_oe();
      stop_test();
   end
   initial begin
      repeat (3000) @(posedge clk_i);
      failures++;
      $display("mismatch t=%0t watchdog expired", $time);
      stop_test();
   end
endmodule
`default_nettype wire
